/* pmwf_pkg.sv */
// Notes on behaviour
// - Leaving system reset puts the device in RUN mode.
// - RUN and HALT each report one of four system clock sources.
// - Halt instruction enters HALT; clocks and peripherals keep running.
// - Sleep instruction enters SLEEP; sources with sleep-keep set stop.
// - Sources with sleep-keep clear keep running during SLEEP.
// - Debug interrupt enters DEBUG; debug-return instruction ends it.
// - Cancel raised by peripheral request, watchdog NMI, debug interrupt, reset or an enabled flag request.
// - Return to RUN happens even if the CPU ignores the request.
// - Mode-done flag sets when leaving super economy completes; write 1 clears.
// - In automatic mode, normal-to-economy completion also sets mode-done.
// - Mode-done flag sets only while the low-speed crystal runs.
// - Automatic mode, SLEEP on crystal only: flag sets 1 ms later, may wake.
// - Each oscillator stable flag sets after its wait; write 1 clears.
// - Low-speed-stop flag sets on clock stop or enable falling; write 1 clears.
// - Trim-done flag sets when auto-trimming completes; write 1 clears.
// - Each flag has an enable; request only when set and enabled.
// - Mode codes auto 0, normal 2, economy 3, super economy 5; reserved stores 0.
package pmwf_pkg;
  typedef enum logic [1:0] {
    PMWF_RUN,
    PMWF_HALT,
    PMWF_SLEEP,
    PMWF_DEBUG
  } pmwf_mode_e;

  localparam logic [2:0] PMWF_PG_AUTO = 3'h0;
  localparam logic [2:0] PMWF_PG_NORMAL = 3'h2;
  localparam logic [2:0] PMWF_PG_ECONOMY = 3'h3;
  localparam logic [2:0] PMWF_PG_SUPER = 3'h5;
  localparam logic [2:0] PMWF_PG_RESET = 3'h0;

  // Clock source codes, also the sleep-keep bit index
  localparam logic [1:0] PMWF_SRC_INTERNAL = 2'h0;
  localparam logic [1:0] PMWF_SRC_LOW = 2'h1;
  localparam logic [1:0] PMWF_SRC_HIGH = 2'h2;
  localparam logic [1:0] PMWF_SRC_EXT = 2'h3;
  localparam int PMWF_NUM_SRC = 4;

  // Flag bit positions
  localparam int PMWF_NUM_FLAGS = 6;
  localparam int PMWF_F_MODE_DONE = 0;
  localparam int PMWF_F_INT_STABLE = 1;
  localparam int PMWF_F_LOW_STABLE = 2;
  localparam int PMWF_F_HIGH_STABLE = 3;
  localparam int PMWF_F_LOW_STOP = 4;
  localparam int PMWF_F_TRIM_DONE = 5;

  localparam int PMWF_CLK_MHZ = 250;
  localparam int PMWF_SLEEP_DELAY_US = 1000;
  localparam int PMWF_SLEEP_DELAY_CYC = PMWF_SLEEP_DELAY_US * PMWF_CLK_MHZ;
  localparam int PMWF_SYNC_STAGES = 3;
endpackage

/* pmwf_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; change accepted when stages two and three agree
module pmwf_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        out_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : out_q[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign o_sync = out_q;
endmodule
`default_nettype wire

/* pmwf_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pmwf_top #(
  parameter int SLEEP_DELAY_CYC = pmwf_pkg::PMWF_SLEEP_DELAY_CYC
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  // CPU and system events, same clock domain
  input wire logic i_sys_reset_req,
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic i_debug_irq,
  input wire logic i_debug_return,
  input wire logic i_periph_irq,
  input wire logic i_wdt_nmi,
  input wire logic [1:0] i_system_clock_src,
  input wire logic [3:0] i_osc_enable,
  input wire logic [3:0] i_osc_sleep_keep,
  // Power generator mode control
  input wire logic i_power_gen_mode_wr,
  input wire logic [2:0] i_power_gen_mode_wdata,
  input wire logic i_pg_transition_done,
  input wire logic [2:0] i_pg_from_mode,
  input wire logic [2:0] i_pg_to_mode,
  // Clock generator events
  input wire logic i_internal_osc_stable,
  input wire logic i_low_osc_stable,
  input wire logic i_high_osc_stable,
  input wire logic i_low_speed_crystal_running,
  input wire logic i_trim_done,
  input wire logic i_stop_detect_enable,
  // Flag access
  input wire logic i_flag_clr_wr,
  input wire logic [5:0] i_flag_clr_mask,
  input wire logic [5:0] i_flag_enable,
  output logic [1:0] o_mode,
  output logic [1:0] o_mode_clk_src,
  output logic o_cpu_stopped,
  output logic [3:0] o_osc_run,
  output logic o_cancel,
  output logic [2:0] o_power_gen_mode_select,
  output logic [5:0] o_flags,
  output logic o_irq
);
  localparam int NF = pmwf_pkg::PMWF_NUM_FLAGS;
  localparam int NS = pmwf_pkg::PMWF_NUM_SRC;
  localparam int CW = $clog2(SLEEP_DELAY_CYC + 1);
  localparam logic [CW-1:0] DELAY_LAST = CW'(SLEEP_DELAY_CYC - 1);

  pmwf_pkg::pmwf_mode_e mode_q;
  pmwf_pkg::pmwf_mode_e mode_d;
  logic [1:0] src_q;
  logic [1:0] src_d;
  logic cancel_q;
  logic cancel_d;
  logic stopped_q;
  logic stopped_d;
  logic [NS-1:0] osc_run_q;
  logic [NS-1:0] osc_run_d;
  logic [2:0] pg_mode_q;
  logic [2:0] pg_mode_d;
  logic [NF-1:0] flags_q;
  logic [NF-1:0] flags_d;
  logic [NF-1:0] set_ev;
  logic irq_q;
  logic irq_d;
  logic [CW-1:0] dly_q;
  logic [CW-1:0] dly_d;
  logic dly_run_q;
  logic dly_run_d;

  // Oscillator status arrives from the analogue side
  logic [4:0] async_in;
  logic [4:0] sync_out;
  logic int_stable_s;
  logic low_stable_s;
  logic high_stable_s;
  logic crystal_s;
  logic trim_s;
  logic [4:0] sync_prev_q;
  logic low_en_prev_q;
  logic osd_en_prev_q;

  assign async_in = {i_trim_done, i_low_speed_crystal_running, i_high_osc_stable,
                     i_low_osc_stable, i_internal_osc_stable};

  pmwf_sync #(
    .WIDTH(5)
  ) u_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_async(async_in),
    .o_sync(sync_out)
  );

  assign int_stable_s = sync_out[0];
  assign low_stable_s = sync_out[1];
  assign high_stable_s = sync_out[2];
  assign crystal_s = sync_out[3];
  assign trim_s = sync_out[4];

  // Operating mode and cancel
  logic wake_any;
  always_comb begin
    wake_any = i_periph_irq || i_wdt_nmi || i_debug_irq || i_sys_reset_req;
    mode_d = mode_q;
    src_d = i_system_clock_src;
    cancel_d = 1'b0;
    case (mode_q)
      pmwf_pkg::PMWF_RUN: begin
        if (i_debug_irq) begin
          mode_d = pmwf_pkg::PMWF_DEBUG;
        end else if (i_sleep_exec) begin
          mode_d = pmwf_pkg::PMWF_SLEEP;
        end else if (i_halt_exec) begin
          mode_d = pmwf_pkg::PMWF_HALT;
        end
      end
      pmwf_pkg::PMWF_HALT, pmwf_pkg::PMWF_SLEEP: begin
        // No acknowledge is awaited; wake does not depend on the CPU taking it
        if (wake_any || irq_q) begin
          cancel_d = 1'b1;
          if (i_debug_irq) begin
            mode_d = pmwf_pkg::PMWF_DEBUG;
          end else begin
            mode_d = pmwf_pkg::PMWF_RUN;
          end
        end
      end
      pmwf_pkg::PMWF_DEBUG: begin
        if (i_debug_return) begin
          mode_d = pmwf_pkg::PMWF_RUN;
        end
      end
      default: mode_d = pmwf_pkg::PMWF_RUN;
    endcase
    if (i_sys_reset_req) begin
      mode_d = pmwf_pkg::PMWF_RUN;
    end
    stopped_d = (mode_d == pmwf_pkg::PMWF_HALT) || (mode_d == pmwf_pkg::PMWF_SLEEP);
  end

  // Clock sources: enabled ones run, except sleep-keep ones in SLEEP
  genvar gs;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_src
      always_comb begin
        if (mode_d == pmwf_pkg::PMWF_SLEEP) begin
          osc_run_d[gs] = i_osc_enable[gs] && !i_osc_sleep_keep[gs];
        end else begin
          osc_run_d[gs] = i_osc_enable[gs];
        end
      end
    end
  endgenerate

  // Power generator mode select
  always_comb begin
    pg_mode_d = pg_mode_q;
    if (i_power_gen_mode_wr) begin
      case (i_power_gen_mode_wdata)
        pmwf_pkg::PMWF_PG_AUTO,
        pmwf_pkg::PMWF_PG_NORMAL,
        pmwf_pkg::PMWF_PG_ECONOMY,
        pmwf_pkg::PMWF_PG_SUPER: pg_mode_d = i_power_gen_mode_wdata;
        default: pg_mode_d = pmwf_pkg::PMWF_PG_AUTO;
      endcase
    end
  end

  // Sleep delay timer: auto mode, sleeping with only the crystal left
  logic crystal_only;
  always_comb begin
    crystal_only = osc_run_q[pmwf_pkg::PMWF_SRC_LOW] && !osc_run_q[pmwf_pkg::PMWF_SRC_INTERNAL]
                   && !osc_run_q[pmwf_pkg::PMWF_SRC_HIGH] && !osc_run_q[pmwf_pkg::PMWF_SRC_EXT];
    dly_d = dly_q;
    dly_run_d = dly_run_q;
    set_ev = '0;
    if (mode_q != pmwf_pkg::PMWF_SLEEP || pg_mode_q != pmwf_pkg::PMWF_PG_AUTO || !crystal_only) begin
      dly_run_d = 1'b0;
      dly_d = '0;
    end else if (!dly_run_q) begin
      // First SLEEP cycle already counts, so the flag lands SLEEP_DELAY_CYC after entry
      dly_run_d = 1'b1;
      dly_d = CW'(1);
    end else if (dly_q == DELAY_LAST) begin
      // One-shot per SLEEP entry
      set_ev[pmwf_pkg::PMWF_F_MODE_DONE] = crystal_s;
      dly_d = dly_q + CW'(1);
    end else if (dly_q < DELAY_LAST) begin
      dly_d = dly_q + CW'(1);
    end
    if (i_pg_transition_done && crystal_s) begin
      if (i_pg_from_mode == pmwf_pkg::PMWF_PG_SUPER && i_pg_to_mode != pmwf_pkg::PMWF_PG_SUPER) begin
        set_ev[pmwf_pkg::PMWF_F_MODE_DONE] = 1'b1;
      end
      if (pg_mode_q == pmwf_pkg::PMWF_PG_AUTO && i_pg_from_mode == pmwf_pkg::PMWF_PG_NORMAL
          && i_pg_to_mode == pmwf_pkg::PMWF_PG_ECONOMY) begin
        set_ev[pmwf_pkg::PMWF_F_MODE_DONE] = 1'b1;
      end
    end
    set_ev[pmwf_pkg::PMWF_F_INT_STABLE] = int_stable_s && !sync_prev_q[0];
    set_ev[pmwf_pkg::PMWF_F_LOW_STABLE] = low_stable_s && !sync_prev_q[1];
    set_ev[pmwf_pkg::PMWF_F_HIGH_STABLE] = high_stable_s && !sync_prev_q[2];
    set_ev[pmwf_pkg::PMWF_F_LOW_STOP] = (!crystal_s && sync_prev_q[3])
        || (low_en_prev_q && !i_osc_enable[pmwf_pkg::PMWF_SRC_LOW])
        || (osd_en_prev_q && !i_stop_detect_enable);
    set_ev[pmwf_pkg::PMWF_F_TRIM_DONE] = trim_s && !sync_prev_q[4];
  end

  // Event flags: set wins over a same-cycle clear
  genvar gf;
  generate
    for (gf = 0; gf < NF; gf++) begin : g_flag
      always_comb begin
        if (set_ev[gf]) begin
          flags_d[gf] = 1'b1;
        end else if (i_flag_clr_wr && i_flag_clr_mask[gf]) begin
          flags_d[gf] = 1'b0;
        end else begin
          flags_d[gf] = flags_q[gf];
        end
      end
    end
  endgenerate

  always_comb begin
    irq_d = |(flags_d & i_flag_enable);
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode_q <= pmwf_pkg::PMWF_RUN;
      src_q <= pmwf_pkg::PMWF_SRC_INTERNAL;
      cancel_q <= 1'b0;
      stopped_q <= 1'b0;
      osc_run_q <= '0;
      pg_mode_q <= pmwf_pkg::PMWF_PG_RESET;
      flags_q <= '0;
      irq_q <= 1'b0;
      dly_q <= '0;
      dly_run_q <= 1'b0;
      sync_prev_q <= '0;
      low_en_prev_q <= 1'b0;
      osd_en_prev_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      src_q <= src_d;
      cancel_q <= cancel_d;
      stopped_q <= stopped_d;
      osc_run_q <= osc_run_d;
      pg_mode_q <= pg_mode_d;
      flags_q <= flags_d;
      irq_q <= irq_d;
      dly_q <= dly_d;
      dly_run_q <= dly_run_d;
      sync_prev_q <= sync_out;
      low_en_prev_q <= i_osc_enable[pmwf_pkg::PMWF_SRC_LOW];
      osd_en_prev_q <= i_stop_detect_enable;
    end
  end

  assign o_mode = mode_q;
  assign o_mode_clk_src = src_q;
  assign o_cpu_stopped = stopped_q;
  assign o_osc_run = osc_run_q;
  assign o_cancel = cancel_q;
  assign o_power_gen_mode_select = pg_mode_q;
  assign o_flags = flags_q;
  assign o_irq = irq_q;
endmodule
`default_nettype wire

/* pmwf_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module pmwf_properties (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_sys_reset_req,
  input wire logic i_halt_exec,
  input wire logic i_sleep_exec,
  input wire logic i_debug_irq,
  input wire logic i_debug_return,
  input wire logic i_periph_irq,
  input wire logic i_wdt_nmi,
  input wire logic [1:0] i_system_clock_src,
  input wire logic [3:0] i_osc_enable,
  input wire logic [3:0] i_osc_sleep_keep,
  input wire logic i_power_gen_mode_wr,
  input wire logic [2:0] i_power_gen_mode_wdata,
  input wire logic i_flag_clr_wr,
  input wire logic [5:0] i_flag_clr_mask,
  input wire logic [5:0] i_flag_enable,
  input wire logic [1:0] o_mode,
  input wire logic [1:0] o_mode_clk_src,
  input wire logic o_cpu_stopped,
  input wire logic [3:0] o_osc_run,
  input wire logic o_cancel,
  input wire logic [2:0] o_power_gen_mode_select,
  input wire logic [5:0] o_flags,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  // Flags that must survive into the next cycle
  logic [5:0] keep_q;
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n) keep_q <= '0;
    else keep_q <= o_flags & ~({6{i_flag_clr_wr}} & i_flag_clr_mask);
  sequence s_in_run;
    o_mode == 2'h0 && !i_sys_reset_req && !i_debug_irq;
  endsequence
  sequence s_wake_req;
    o_cpu_stopped && (i_periph_irq || i_wdt_nmi) && !i_debug_irq;
  endsequence
  a_halt_entry: assert property (s_in_run ##0 (i_halt_exec && !i_sleep_exec) |=> o_mode == 2'h1)
    else $error("halt not entered");
  a_sleep_entry: assert property (s_in_run ##0 i_sleep_exec |=> o_mode == 2'h2)
    else $error("sleep not entered");
  a_debug_entry: assert property (o_mode != 2'h3 && i_debug_irq && !i_sys_reset_req |=> o_mode == 2'h3)
    else $error("debug not entered");
  a_debug_exit: assert property (o_mode == 2'h3 && i_debug_return && !i_debug_irq && !i_sys_reset_req |=> o_mode == 2'h0)
    else $error("debug not left");
  a_wake_cancel: assert property (s_wake_req |=> o_mode == 2'h0 && o_cancel)
    else $error("stop mode not cancelled");
  a_cancel_pulse: assert property (o_cancel |=> !o_cancel)
    else $error("cancel longer than one cycle");
  a_osc_sleep: assert property (o_mode == 2'h2 && $past(o_mode) == 2'h2 && $stable(i_osc_enable) && $stable(i_osc_sleep_keep) |-> o_osc_run == (i_osc_enable & ~i_osc_sleep_keep))
    else $error("sleep clock gating wrong");
  a_irq_or: assert property ($stable(i_flag_enable) |-> o_irq == |(o_flags & i_flag_enable))
    else $error("irq not or of enabled flags");
  a_flag_hold: assert property ((o_flags & keep_q) == keep_q)
    else $error("flag lost without clear");
  a_pg_store: assert property (i_power_gen_mode_wr |=> o_power_gen_mode_select == (($past(i_power_gen_mode_wdata) inside {3'h0, 3'h2, 3'h3, 3'h5}) ? $past(i_power_gen_mode_wdata) : 3'h0))
    else $error("mode select store wrong");
  a_src_track: assert property (o_mode_clk_src == $past(i_system_clock_src))
    else $error("clock source not tracked");
  a_stop_decode: assert property (o_cpu_stopped == (o_mode == 2'h1 || o_mode == 2'h2))
    else $error("cpu stopped flag disagrees with mode");
endmodule
bind pmwf_top pmwf_properties pmwf_properties_i (.*);
`default_nettype wire

/* pmwf_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
// CPU stand-in; never acknowledges an interrupt, so wakes come from cancel alone
module pmwf_cpu_model (
  input wire logic i_clock,
  input wire logic i_cancel,
  output logic o_halt,
  output logic o_sleep,
  output logic o_dret,
  output int o_wakes
);
  initial begin
    {o_halt, o_sleep, o_dret} = '0;
    o_wakes = 0;
  end
  always @(posedge i_clock) if (i_cancel) o_wakes <= o_wakes + 1;
  // One-cycle instruction pulse: 0 halt, 1 sleep, 2 debug return
  task automatic exec(input int k);
    @(posedge i_clock);
    o_halt <= (k == 0);
    o_sleep <= (k == 1);
    o_dret <= (k == 2);
    @(posedge i_clock);
    {o_halt, o_sleep, o_dret} <= '0;
    #1;
  endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, rreq = 0, dirq = 0, pirq = 0, nmi = 0, pgwr = 0, pgdn = 0, clrwr = 0;
  logic ist = 0, lst = 0, hst = 0, xrun = 0, trim = 0, sde = 0;
  logic [1:0] src = '0, mode, msrc;
  logic [3:0] oen = '0, keep = '0, orun;
  logic [2:0] pgw = '0, pgf = '0, pgt = '0, pgsel;
  logic [5:0] clrm = '0, fen = '0, flags;
  logic halt, slp, dret, stop, cancel, irq;
  int wakes, err_count = 0, tests_run = 0;
  always #2 clk = ~clk;
  pmwf_top #(.SLEEP_DELAY_CYC(20)) pmwf_top_i (.i_clock(clk), .i_arst_n(rst_n), .i_sys_reset_req(rreq),
    .i_halt_exec(halt), .i_sleep_exec(slp), .i_debug_irq(dirq), .i_debug_return(dret), .i_periph_irq(pirq),
    .i_wdt_nmi(nmi), .i_system_clock_src(src), .i_osc_enable(oen), .i_osc_sleep_keep(keep),
    .i_power_gen_mode_wr(pgwr), .i_power_gen_mode_wdata(pgw), .i_pg_transition_done(pgdn),
    .i_pg_from_mode(pgf), .i_pg_to_mode(pgt), .i_internal_osc_stable(ist), .i_low_osc_stable(lst),
    .i_high_osc_stable(hst), .i_low_speed_crystal_running(xrun), .i_trim_done(trim),
    .i_stop_detect_enable(sde), .i_flag_clr_wr(clrwr), .i_flag_clr_mask(clrm), .i_flag_enable(fen),
    .o_mode(mode), .o_mode_clk_src(msrc), .o_cpu_stopped(stop), .o_osc_run(orun), .o_cancel(cancel),
    .o_power_gen_mode_select(pgsel), .o_flags(flags), .o_irq(irq));
  pmwf_cpu_model pmwf_cpu_model_i (.i_clock(clk), .i_cancel(cancel), .o_halt(halt), .o_sleep(slp),
    .o_dret(dret), .o_wakes(wakes));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Completed power generator transition, then clear all flags
  task automatic pg_done(input logic [2:0] f, input logic [2:0] t, input logic [7:0] exp);
    @(posedge clk);
    pgdn <= 1'h1;
    pgf <= f;
    pgt <= t;
    @(posedge clk);
    pgdn <= 1'h0;
    #1;
    chk({2'h0, flags}, exp);
    @(posedge clk);
    clrwr <= 1'h1;
    clrm <= 6'h3f;
    @(posedge clk);
    clrwr <= 1'h0;
  endtask
  initial begin
    #20000;
    err_count++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    tick(1);
    chk(8'({pgsel, mode}), 8'h0);
    oen <= 4'hf;
    keep <= 4'h5;
    fen <= '0;
    for (int k = 0; k < 4; k++) begin
      pmwf_cpu_model_i.exec(k % 2);
      chk(8'({stop, mode}), 8'(5 + k % 2));
      chk(8'(orun), (k % 2) ? 8'ha : 8'hf);
      @(posedge clk);
      {rreq, dirq, nmi, pirq} <= 4'h1 << k;
      @(posedge clk);
      {rreq, dirq, nmi, pirq} <= '0;
      #1;
      chk(8'({cancel, mode}), (k == 2) ? 8'h7 : 8'h4);
      if (k == 2) pmwf_cpu_model_i.exec(2);
      chk(8'(mode), 8'h0);
    end
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      src <= 2'(s);
      tick(1);
      chk(8'(msrc), 8'(s));
    end
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      pgwr <= 1'h1;
      pgw <= 3'(m);
      tick(1);
      chk(8'(pgsel), (m inside {0, 2, 3, 5}) ? 8'(m) : 8'h0);
    end
    @(posedge clk);
    pgwr <= 1'h0;
    {ist, lst, hst, trim} <= 4'hf;
    fen <= 6'h2a;
    tick(6);
    chk({irq, 1'h0, flags}, 8'hae);
    @(posedge clk);
    clrwr <= 1'h1;
    clrm <= 6'h11;
    @(posedge clk);
    clrm <= 6'h2a;
    @(posedge clk);
    clrwr <= 1'h0;
    sde <= 1'h1;
    xrun <= 1'h1;
    tick(6);
    chk({irq, 1'h0, flags}, 8'h04);
    @(posedge clk);
    sde <= 1'h0;
    tick(3);
    chk(8'(flags), 8'h14);
    @(posedge clk);
    clrwr <= 1'h1;
    clrm <= 6'h3f;
    oen <= 4'hd;
    @(posedge clk);
    clrwr <= 1'h0;
    oen <= 4'hf;
    tick(3);
    chk(8'(flags), 8'h10);
    @(posedge clk);
    clrwr <= 1'h1;
    clrm <= 6'h10;
    xrun <= 1'h0;
    @(posedge clk);
    clrwr <= 1'h0;
    tick(6);
    chk(8'(flags), 8'h10);
    pg_done(3'h5, 3'h2, 8'h10);
    xrun <= 1'h1;
    tick(6);
    pg_done(3'h5, 3'h3, 8'h01);
    pg_done(3'h2, 3'h3, 8'h01);
    pg_done(3'h3, 3'h2, 8'h00);
    oen <= 4'h2;
    keep <= 4'hd;
    fen <= 6'h01;
    pmwf_cpu_model_i.exec(1);
    // Flag due exactly SLEEP_DELAY_CYC cycles after SLEEP entry
    tick(19);
    chk({flags, mode}, 8'h02);
    tick(1);
    chk({irq, 1'h0, flags}, 8'h81);
    tick(1);
    chk(8'({cancel, mode}), 8'h04);
    // Model counts a wake at the edge after cancel appears
    tick(1);
    chk(8'(wakes), 8'h5);
    stop_test();
  end
endmodule
`default_nettype wire
